// >>> pkg/rps_defines.svh
// offsets, field positions, reset values and timing counts
`ifndef RPS_DEFINES_SVH
`define RPS_DEFINES_SVH

`define RPS_ADDR_CTRL       5'h00
`define RPS_ADDR_CMD        5'h04
`define RPS_ADDR_LIMIT      5'h08
`define RPS_ADDR_DELTA      5'h0C
`define RPS_ADDR_ACTION     5'h10
`define RPS_ADDR_STATUS     5'h14
`define RPS_ADDR_MARK       5'h18
`define RPS_ADDR_MTIME      5'h1C

`define RPS_CTRL_MANUAL     0
`define RPS_CTRL_TRACK      1
`define RPS_CTRL_UPDATE     2
`define RPS_ACT_START       0
`define RPS_ACT_PROCEED     1
`define RPS_ACT_REDESIG     2
`define RPS_ACT_ABORT       3

`define RPS_CTRL_RESET      32'h0000_0000
`define RPS_CMD_RESET       32'h0000_0000
`define RPS_LIMIT_RESET     32'hFFFF_FFFF
`define RPS_DELTA_RESET     32'h0000_0000

// angles in hundredths of a degree
`define RPS_ALIGN_TOL       16'h0032
`define RPS_SIDELOBE_TOL    16'h012C
`define RPS_ZAXIS_LIMIT     16'h0BB8
`define RPS_DEADBAND        16'h001E
`define RPS_SEARCH_SIDE     16'h0230
`define RPS_SEARCH_HALF     16'h0118

`define RPS_ALARM_SEARCH    16'h0503

// times in milliseconds, counted in half-second ticks
`define RPS_TICK_MS         500
`define RPS_DESIG_MS        30000
`define RPS_REQUEST_MS      60000
`define RPS_PASS_MS         42000
`define RPS_DESIG_TICKS     ((`RPS_DESIG_MS) / (`RPS_TICK_MS))
`define RPS_REQUEST_TICKS   ((`RPS_REQUEST_MS) / (`RPS_TICK_MS))
`define RPS_LEG_TICKS       ((`RPS_PASS_MS) / (`RPS_TICK_MS) / 4)

`endif

// >>> pkg/rps_pkg.sv
// types shared by the pointing and acquisition sequencer
package rps_pkg;

    typedef enum logic [9:0] {
        RPS_IDLE     = 10'h001,
        RPS_ALIGN    = 10'h002,
        RPS_DESIG    = 10'h004,
        RPS_SALARM   = 10'h008,
        RPS_SEARCH   = 10'h010,
        RPS_TRACK    = 10'h020,
        RPS_READ     = 10'h040,
        RPS_SIDELOBE = 10'h080,
        RPS_DEVIATE  = 10'h100,
        RPS_MANUAL   = 10'h200
    } rps_state_e;

    typedef struct packed {
        logic signed [15:0] trunnion;
        logic signed [15:0] shaft;
    } rps_angles_s;

    typedef struct packed {
        logic lockOn;
        logic autoMode;
        logic lowScale;
        logic gimbalOverLimit;
    } rps_discretes_s;

endpackage : rps_pkg

// >>> logic/rps_pointing_seq.sv
// radar pointing and acquisition sequencer with avalon register slave
// What this block does
// - new angle command set every half second
// - load command minus readback into error counters
// - assert track enable within 0.5 degrees
// - lock-on ends designation, else keep commanding
// - no lock after 30 s raises search alarm
// - proceed on search alarm starts search
// - request navigation update once per minute
// - track flag clear: no data request, no actions
// - check enable, else realign, redesignate; auto mode clear: no readout
// - gimbal over limit withdraws track enable
// - sample lock-on throughout data readout
// - scale change discards set, requests new set
// - stamp data set with angle capture instant
// - over 3 degrees: sidelobe alarm, await choice
// - update only with update flag set
// - over thresholds: withhold update, show deltas
// - square search pattern 5.6 degrees about sight line
// - one search pass takes about 42 seconds
// - track enable held during search commands
// - offset over 30 degrees: realign before pattern
// - manual: hold 0.3 deadband, then enable track
//
// The register offsets and register access over Avalon-MM are this design's own decisions.
`include "rps_defines.svh"

module rps_pointing_seq (
    input  wire logic                    clk,
    input  wire logic                    reset,
    input  wire logic [4:0]              avsAddress,
    input  wire logic                    avsRead,
    input  wire logic                    avsWrite,
    input  wire logic [3:0]              avsByteEnable,
    input  wire logic [31:0]             avsWriteData,
    output logic [31:0]                  avsReadData,
    output logic                         avsWaitRequest,
    input  wire logic                    tick,
    input  wire rps_pkg::rps_discretes_s radarIn,
    input  wire rps_pkg::rps_angles_s    antAngle,
    input  wire logic [15:0]             zOffset,
    input  wire logic                    dataReady,
    output logic                         trackEnable,
    output logic                         errLoad,
    output rps_pkg::rps_angles_s         errPulses,
    output logic                         navRequest,
    output logic                         dataRequest,
    output logic                         alignRequest,
    output logic                         searchAlarm,
    output logic                         sidelobeAlarm,
    output logic                         deviationAlarm,
    output logic [15:0]                  alarmCode,
    output logic                         stateUpdate,
    output logic                         lowScaleUsed
);

    rps_pkg::rps_state_e  state_reg;
    rps_pkg::rps_state_e  retState_reg;
    rps_pkg::rps_angles_s markAngle_reg;
    rps_pkg::rps_angles_s errPulses_reg;
    logic [31:0]          ctrl_reg;
    logic [31:0]          cmd_reg;
    logic [31:0]          limit_reg;
    logic [31:0]          delta_reg;
    logic [31:0]          markTime_reg;
    logic [31:0]          tickCount_reg;
    logic [31:0]          readData_reg;
    logic [15:0]          alarmCode_reg;
    logic [6:0]           timer_reg;
    logic [1:0]           leg_reg;
    logic                 ack_reg;
    logic                 trackEnable_reg;
    logic                 lastScale_reg;
    logic                 lockLost_reg;
    logic                 errLoad_reg;
    logic                 navRequest_reg;
    logic                 dataRequest_reg;
    logic                 stateUpdate_reg;
    logic                 busWrite;
    logic                 actStart;
    logic                 actProceed;
    logic                 actRedesig;
    logic                 actAbort;
    logic                 updateBlocked;
    rps_pkg::rps_angles_s line_of_sight;
    rps_pkg::rps_angles_s searchCmd;
    rps_pkg::rps_angles_s liveCmd;
    logic [31:0]          statusWord;

    function automatic logic [15:0] absDiff(
        input logic signed [15:0] a,
        input logic signed [15:0] b
    );
        logic signed [16:0] d;
        d = 17'({a[15], a}) - 17'({b[15], b});
        absDiff = d[16] ? 16'(-d) : d[15:0];
    endfunction : absDiff

    function automatic logic beyond(
        input rps_pkg::rps_angles_s a,
        input rps_pkg::rps_angles_s b,
        input logic [15:0]          lim
    );
        beyond = (absDiff(a.shaft, b.shaft) > lim)
              || (absDiff(a.trunnion, b.trunnion) > lim);
    endfunction : beyond

    function automatic logic signed [15:0] legPos(input logic [6:0] cnt);
        logic [31:0] p;
        p = (32'(`RPS_SEARCH_SIDE) * 32'(cnt)) / 32'(`RPS_LEG_TICKS - 1);
        legPos = 16'(p) - `RPS_SEARCH_HALF;
    endfunction : legPos

    function automatic logic [31:0] mergeBytes(
        input logic [31:0] old,
        input logic [31:0] data,
        input logic [3:0]  be
    );
        for (int i = 0; i < 4; i++) begin
            old[i*8 +: 8] = be[i] ? data[i*8 +: 8] : old[i*8 +: 8];
        end
        mergeBytes = old;
    endfunction : mergeBytes

    // bus: one wait cycle, answer at the second edge
    assign avsWaitRequest = (avsRead || avsWrite) && !ack_reg;
    assign busWrite       = avsWrite && ack_reg;
    assign actStart   = busWrite && avsAddress == `RPS_ADDR_ACTION
                     && avsByteEnable[0] && avsWriteData[`RPS_ACT_START];
    assign actProceed = busWrite && avsAddress == `RPS_ADDR_ACTION
                     && avsByteEnable[0] && avsWriteData[`RPS_ACT_PROCEED];
    assign actRedesig = busWrite && avsAddress == `RPS_ADDR_ACTION
                     && avsByteEnable[0] && avsWriteData[`RPS_ACT_REDESIG];
    assign actAbort   = busWrite && avsAddress == `RPS_ADDR_ACTION
                     && avsByteEnable[0] && avsWriteData[`RPS_ACT_ABORT];

    assign line_of_sight = rps_pkg::rps_angles_s'(cmd_reg);
    assign statusWord = {16'h0000, lockLost_reg, lastScale_reg,
                         trackEnable_reg, 3'h0, 10'(state_reg)};

    // search corners walked leg by leg about the sight line
    always_comb begin
        searchCmd = line_of_sight;
        unique case (leg_reg)
            2'h0: begin
                searchCmd.shaft    = line_of_sight.shaft + legPos(timer_reg);
                searchCmd.trunnion = line_of_sight.trunnion - `RPS_SEARCH_HALF;
            end
            2'h1: begin
                searchCmd.shaft    = line_of_sight.shaft + `RPS_SEARCH_HALF;
                searchCmd.trunnion = line_of_sight.trunnion + legPos(timer_reg);
            end
            2'h2: begin
                searchCmd.shaft    = line_of_sight.shaft - legPos(timer_reg);
                searchCmd.trunnion = line_of_sight.trunnion + `RPS_SEARCH_HALF;
            end
            2'h3: begin
                searchCmd.shaft    = line_of_sight.shaft - `RPS_SEARCH_HALF;
                searchCmd.trunnion = line_of_sight.trunnion - legPos(timer_reg);
            end
        endcase
        liveCmd = (state_reg == rps_pkg::RPS_SEARCH) ? searchCmd : line_of_sight;
    end

    // deltas checked against alarm thresholds
    assign updateBlocked = (delta_reg[15:0] > limit_reg[15:0])
                        || (delta_reg[31:16] > limit_reg[31:16]);

    // bus handshake and read data
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            ack_reg      <= 1'b0;
            readData_reg <= 32'h0000_0000;
        end else begin
            ack_reg <= (avsRead || avsWrite) && !ack_reg;
            if (avsRead && !ack_reg) begin
                unique case (avsAddress)
                    `RPS_ADDR_CTRL:   readData_reg <= ctrl_reg;
                    `RPS_ADDR_CMD:    readData_reg <= cmd_reg;
                    `RPS_ADDR_LIMIT:  readData_reg <= limit_reg;
                    `RPS_ADDR_DELTA:  readData_reg <= delta_reg;
                    `RPS_ADDR_STATUS: readData_reg <= statusWord;
                    `RPS_ADDR_MARK:   readData_reg <= markAngle_reg;
                    `RPS_ADDR_MTIME:  readData_reg <= markTime_reg;
                    default:          readData_reg <= 32'h0000_0000;
                endcase
            end
        end
    end

    // software written configuration
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            ctrl_reg  <= `RPS_CTRL_RESET;
            cmd_reg   <= `RPS_CMD_RESET;
            limit_reg <= `RPS_LIMIT_RESET;
            delta_reg <= `RPS_DELTA_RESET;
        end else if (busWrite) begin
            unique case (avsAddress)
                `RPS_ADDR_CTRL:
                    ctrl_reg  <= mergeBytes(ctrl_reg, avsWriteData,
                                            avsByteEnable);
                `RPS_ADDR_CMD:
                    cmd_reg   <= mergeBytes(cmd_reg, avsWriteData,
                                            avsByteEnable);
                `RPS_ADDR_LIMIT:
                    limit_reg <= mergeBytes(limit_reg, avsWriteData,
                                            avsByteEnable);
                `RPS_ADDR_DELTA:
                    delta_reg <= mergeBytes(delta_reg, avsWriteData,
                                            avsByteEnable);
                default: ;
            endcase
        end
    end

    // free running tick count for time stamps
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            tickCount_reg <= 32'h0000_0000;
        end else if (tick) begin
            tickCount_reg <= tickCount_reg + 32'h0000_0001;
        end
    end

    // track enable discrete
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            trackEnable_reg <= 1'b0;
        end else if (radarIn.gimbalOverLimit) begin
            trackEnable_reg <= 1'b0;
        end else if (actAbort || state_reg == rps_pkg::RPS_IDLE) begin
            trackEnable_reg <= 1'b0;
        end else if (state_reg == rps_pkg::RPS_DESIG
                     && !beyond(line_of_sight, antAngle, `RPS_ALIGN_TOL)) begin
            trackEnable_reg <= 1'b1;
        end else if (state_reg == rps_pkg::RPS_SEARCH) begin
            trackEnable_reg <= 1'b1;
        end else if (state_reg == rps_pkg::RPS_MANUAL
                     && zOffset <= `RPS_DEADBAND) begin
            trackEnable_reg <= 1'b1;
        end
    end

    // sequencer
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            state_reg       <= rps_pkg::RPS_IDLE;
            retState_reg    <= rps_pkg::RPS_IDLE;
            timer_reg       <= 7'h00;
            leg_reg         <= 2'h0;
            lastScale_reg   <= 1'b0;
            lockLost_reg    <= 1'b0;
            markAngle_reg   <= 32'h0000_0000;
            markTime_reg    <= 32'h0000_0000;
            errPulses_reg   <= 32'h0000_0000;
            alarmCode_reg   <= 16'h0000;
            errLoad_reg     <= 1'b0;
            navRequest_reg  <= 1'b0;
            dataRequest_reg <= 1'b0;
            stateUpdate_reg <= 1'b0;
        end else begin
            errLoad_reg     <= 1'b0;
            navRequest_reg  <= 1'b0;
            dataRequest_reg <= 1'b0;
            stateUpdate_reg <= 1'b0;
            if (tick && (state_reg == rps_pkg::RPS_DESIG
                         || state_reg == rps_pkg::RPS_SEARCH)) begin
                errPulses_reg.shaft    <= liveCmd.shaft
                                        - antAngle.shaft;
                errPulses_reg.trunnion <= liveCmd.trunnion
                                        - antAngle.trunnion;
                errLoad_reg            <= 1'b1;
            end
            if (actAbort) begin
                state_reg     <= rps_pkg::RPS_IDLE;
                alarmCode_reg <= 16'h0000;
            end else begin
                unique case (state_reg)
                    rps_pkg::RPS_IDLE: if (actStart) begin
                        state_reg    <= rps_pkg::RPS_ALIGN;
                        retState_reg <= ctrl_reg[`RPS_CTRL_MANUAL]
                                      ? rps_pkg::RPS_MANUAL
                                      : rps_pkg::RPS_DESIG;
                        timer_reg    <= 7'h00;
                    end
                    rps_pkg::RPS_ALIGN: if (zOffset <= `RPS_DEADBAND) begin
                        state_reg <= retState_reg;
                        timer_reg <= 7'h00;
                        leg_reg   <= 2'h0;
                    end
                    rps_pkg::RPS_DESIG: begin
                        if (radarIn.lockOn) begin
                            state_reg <= rps_pkg::RPS_TRACK;
                            timer_reg <= 7'h00;
                        end else if (tick && timer_reg
                                == 7'(`RPS_DESIG_TICKS - 1)) begin
                            state_reg     <= rps_pkg::RPS_SALARM;
                            alarmCode_reg <= `RPS_ALARM_SEARCH;
                        end else if (tick) begin
                            timer_reg <= timer_reg + 7'h01;
                        end
                    end
                    rps_pkg::RPS_SALARM: if (actProceed) begin
                        alarmCode_reg <= 16'h0000;
                        timer_reg     <= 7'h00;
                        leg_reg       <= 2'h0;
                        retState_reg  <= rps_pkg::RPS_SEARCH;
                        state_reg     <= (zOffset > `RPS_ZAXIS_LIMIT)
                                       ? rps_pkg::RPS_ALIGN
                                       : rps_pkg::RPS_SEARCH;
                    end
                    rps_pkg::RPS_SEARCH: begin
                        if (actProceed) begin
                            state_reg <= rps_pkg::RPS_TRACK;
                            timer_reg <= 7'h00;
                        end else if (tick && timer_reg
                                == 7'(`RPS_LEG_TICKS - 1)) begin
                            timer_reg <= 7'h00;
                            leg_reg   <= leg_reg + 2'h1;
                            if (leg_reg == 2'h3
                                && zOffset > `RPS_ZAXIS_LIMIT) begin
                                retState_reg <= rps_pkg::RPS_SEARCH;
                                state_reg    <= rps_pkg::RPS_ALIGN;
                            end
                        end else if (tick) begin
                            timer_reg <= timer_reg + 7'h01;
                        end
                    end
                    rps_pkg::RPS_TRACK: if (tick) begin
                        if (timer_reg == 7'(`RPS_REQUEST_TICKS - 1)) begin
                            timer_reg      <= 7'h00;
                            navRequest_reg <= 1'b1;
                            if (!ctrl_reg[`RPS_CTRL_TRACK]) begin
                                state_reg <= rps_pkg::RPS_TRACK;
                            end else if (!trackEnable_reg) begin
                                retState_reg <= rps_pkg::RPS_DESIG;
                                state_reg    <= rps_pkg::RPS_ALIGN;
                            end else if (radarIn.autoMode) begin
                                dataRequest_reg <= 1'b1;
                                lockLost_reg    <= 1'b0;
                                state_reg       <= rps_pkg::RPS_READ;
                            end
                        end else begin
                            timer_reg <= timer_reg + 7'h01;
                        end
                    end
                    rps_pkg::RPS_READ: begin
                        if (!radarIn.lockOn) begin
                            lockLost_reg <= 1'b1;
                        end
                        if (dataReady) begin
                            if (lockLost_reg || !radarIn.lockOn) begin
                                state_reg <= rps_pkg::RPS_TRACK;
                            end else if (radarIn.lowScale
                                         != lastScale_reg) begin
                                lastScale_reg   <= radarIn.lowScale;
                                dataRequest_reg <= 1'b1;
                            end else begin
                                markAngle_reg <= antAngle;
                                markTime_reg  <= tickCount_reg;
                                if (beyond(line_of_sight, antAngle,
                                           `RPS_SIDELOBE_TOL)) begin
                                    state_reg <= rps_pkg::RPS_SIDELOBE;
                                end else if (ctrl_reg[`RPS_CTRL_UPDATE]
                                             && updateBlocked) begin
                                    state_reg <= rps_pkg::RPS_DEVIATE;
                                end else begin
                                    stateUpdate_reg <=
                                        ctrl_reg[`RPS_CTRL_UPDATE];
                                    state_reg <= rps_pkg::RPS_TRACK;
                                end
                            end
                        end
                    end
                    rps_pkg::RPS_SIDELOBE: begin
                        if (actRedesig) begin
                            state_reg <= rps_pkg::RPS_DESIG;
                            timer_reg <= 7'h00;
                        end else if (actProceed) begin
                            if (ctrl_reg[`RPS_CTRL_UPDATE]
                                && updateBlocked) begin
                                state_reg <= rps_pkg::RPS_DEVIATE;
                            end else begin
                                stateUpdate_reg <=
                                    ctrl_reg[`RPS_CTRL_UPDATE];
                                state_reg <= rps_pkg::RPS_TRACK;
                            end
                        end
                    end
                    rps_pkg::RPS_DEVIATE: begin
                        if (actProceed) begin
                            stateUpdate_reg <= 1'b1;
                            state_reg       <= rps_pkg::RPS_TRACK;
                        end else if (actRedesig) begin
                            state_reg <= rps_pkg::RPS_TRACK;
                        end
                    end
                    rps_pkg::RPS_MANUAL:
                        if (radarIn.lockOn && radarIn.autoMode) begin
                            state_reg <= rps_pkg::RPS_TRACK;
                            timer_reg <= 7'h00;
                        end
                    default: state_reg <= rps_pkg::RPS_IDLE;
                endcase
            end
        end
    end

    assign avsReadData    = readData_reg;
    assign trackEnable    = trackEnable_reg;
    assign errLoad        = errLoad_reg;
    assign errPulses      = errPulses_reg;
    assign navRequest     = navRequest_reg;
    assign dataRequest    = dataRequest_reg;
    assign alignRequest   = state_reg == rps_pkg::RPS_ALIGN;
    assign searchAlarm    = state_reg == rps_pkg::RPS_SALARM;
    assign sidelobeAlarm  = state_reg == rps_pkg::RPS_SIDELOBE;
    assign deviationAlarm = state_reg == rps_pkg::RPS_DEVIATE;
    assign alarmCode      = alarmCode_reg;
    assign stateUpdate    = stateUpdate_reg;
    assign lowScaleUsed   = lastScale_reg;

endmodule : rps_pointing_seq

// >>> dv/rps_seq_assertions.sv
// port checks for the pointing sequencer
`include "rps_defines.svh"
module rps_seq_assertions (
    input wire logic clk, reset, avsRead, avsWrite, avsWaitRequest, tick,
    input wire rps_pkg::rps_discretes_s radarIn,
    input wire logic trackEnable, errLoad, navRequest, searchAlarm,
    input wire logic alignRequest,
    input wire logic [15:0] alarmCode
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    wait_first_a: assert property ((avsRead || avsWrite) &&
        !$past(avsRead || avsWrite) |-> avsWaitRequest) else $error("no wait");
    wait_once_a: assert property ((avsRead || avsWrite) && avsWaitRequest
        |=> !avsWaitRequest) else $error("wait held too long");
    err_tick_a: assert property (errLoad |-> $past(tick))
        else $error("error load without tick");
    nav_tick_a: assert property (navRequest |-> $past(tick))
        else $error("nav request without tick");
    code_set_a: assert property (searchAlarm |-> ##[0:1]
        alarmCode == `RPS_ALARM_SEARCH) else $error("alarm code missing");
    code_clear_a: assert property (!searchAlarm && !$past(searchAlarm)
        |-> alarmCode == 16'h0000) else $error("stray alarm code");
    limit_drop_a: assert property (radarIn.gimbalOverLimit |-> ##[1:2]
        !trackEnable) else $error("enable kept over limit");
    alarm_tick_a: assert property ($rose(searchAlarm) |-> $past(tick))
        else $error("alarm without tick");
    cover property (errLoad);
    cover property ($rose(alignRequest));
    cover property ($rose(searchAlarm));
    cover property ($fell(trackEnable));
endmodule : rps_seq_assertions

// >>> dv/rps_radar_model.sv
// far-side radar: servo follows error loads, discretes
module rps_radar_model (
    input  wire logic                 clk,
    input  wire logic                 reset,
    input  wire logic                 errLoad,
    input  wire rps_pkg::rps_angles_s errPulses,
    input  wire logic                 overCmd,
    output rps_pkg::rps_angles_s      antAngle,
    output rps_pkg::rps_discretes_s   radarIn
);
    timeunit 1ns;
    timeprecision 1ps;
    // no lock, auto mode on, long range
    assign radarIn = {1'b0, 1'b1, 1'b0, overCmd};
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            antAngle <= '0;
        end else if (errLoad) begin
            antAngle.shaft    <= antAngle.shaft + errPulses.shaft;
            antAngle.trunnion <= antAngle.trunnion + errPulses.trunnion;
        end
    end
endmodule : rps_radar_model

// >>> dv/radar_pointing_acquisition_seq_bench.sv
// self-checking bench for the pointing sequencer
module radar_pointing_acquisition_seq_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 0, reset = 1, avsRead = 0, avsWrite = 0, tick = 0;
    logic dataReady = 0, overCmd = 0;
    logic [4:0] avsAddress = 5'h00;
    logic [3:0] avsByteEnable = 4'hF;
    logic [31:0] avsWriteData = 32'h0000_0000, avsReadData, cmd;
    logic [15:0] zOffset = 16'h0100, alarmCode;
    logic avsWaitRequest, trackEnable, errLoad, navRequest, dataRequest;
    logic alignRequest, searchAlarm, sidelobeAlarm, deviationAlarm;
    logic stateUpdate, lowScaleUsed;
    rps_pkg::rps_discretes_s radarIn;
    rps_pkg::rps_angles_s antAngle, errPulses;
    logic [31:0] expQ[$], rdQ[$];
    int errCount = 0, nTests = 0, navs = 0, reqs = 0;
    rps_pointing_seq rps_pointing_seq_inst (.*);
    rps_radar_model rps_radar_model_inst (.*);
    always #2.5 clk = ~clk;
    task automatic check(string what, logic [31:0] e, s);
        nTests++;
        if (e !== s) begin
            errCount++;
            $display("CHECK FAILED %s expected %h seen %h", what, e, s);
        end
    endtask : check
    task automatic bus(logic wr, logic [4:0] a, logic [31:0] d);
        if (!wr) rdQ.push_back(d);
        avsAddress <= a;
        avsWriteData <= d;
        avsWrite <= wr;
        avsRead <= !wr;
        do @(posedge clk); while (avsWaitRequest !== 1'b0);
        avsWrite <= 1'b0;
        avsRead <= 1'b0;
        @(posedge clk);
    endtask : bus
    task automatic ticks(int n);
        repeat (n) begin
            tick <= 1'b1;
            @(posedge clk);
            tick <= 1'b0;
            repeat (3) @(posedge clk);
        end
    endtask : ticks
    task automatic complete_run;
        $display("checks %0d mismatches %0d", nTests, errCount);
        if (errCount == 0 && nTests > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : complete_run
    always @(posedge clk) begin
        if (errLoad === 1'b1 && expQ.size() > 0)
            check("errPulses", expQ.pop_front(), errPulses);
        if (avsRead === 1'b1 && avsWaitRequest === 1'b0)
            check("readData", rdQ.pop_front(), avsReadData);
        navs += int'(navRequest === 1'b1);
        reqs += int'(dataRequest === 1'b1);
    end
    initial begin
        void'($urandom(39988));
        cmd = $urandom();
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        bus(0, 5'h00, 32'h0000_0000);
        bus(0, 5'h08, 32'hFFFF_FFFF);
        bus(0, 5'h14, 32'h0000_0001);
        bus(0, 5'h1E, 32'h0000_0000);
        bus(1, 5'h04, cmd);
        bus(1, 5'h10, 32'h0000_0001);
        check("alignRequest", 1'b1, alignRequest);
        expQ = {cmd, 32'h0000_0000, 32'h0000_0000};
        zOffset <= 16'h001E;
        @(posedge clk);
        ticks(3);
        check("trackEnable", 1'b1, trackEnable);
        ticks(57);
        check("searchAlarm", 1'b1, searchAlarm);
        check("alarmCode", 32'h0000_0503, alarmCode);
        bus(1, 5'h10, 32'h0000_0002);
        ticks(2);
        check("searchAlarm", 1'b0, searchAlarm);
        check("trackEnable", 1'b1, trackEnable);
        overCmd <= 1'b1;
        ticks(1);
        check("trackEnable", 1'b0, trackEnable);
        overCmd <= 1'b0;
        bus(1, 5'h10, 32'h0000_0002);
        ticks(120);
        check("navRequest", 1'b1, navs);
        check("dataRequest", 1'b0, reqs);
        bus(1, 5'h00, 32'h0000_0002);
        ticks(120);
        check("dataRequest", 1'b1, reqs);
        dataReady <= 1'b1;
        @(posedge clk);
        dataReady <= 1'b0;
        bus(0, 5'h14, 32'h0000_A020);
        check("stateUpdate", 1'b0, stateUpdate);
        check("sidelobeAlarm", 1'b0, sidelobeAlarm);
        check("deviationAlarm", 1'b0, deviationAlarm);
        check("lowScaleUsed", 1'b0, lowScaleUsed);
        complete_run();
    end
    initial begin
        #50_000;
        errCount++;
        complete_run();
    end
endmodule : radar_pointing_acquisition_seq_bench
bind rps_pointing_seq rps_seq_assertions rps_seq_assertions_inst (.*);
